// *** hw/rsp_pkg.sv ***
package rsp_pkg;
    // ----------------------------------------------------------------
    // bus and register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_CTRL    = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0C;
    localparam logic [7:0] OFF_DIVIDER = 8'h10;
    localparam logic [7:0] OFF_RELOAD  = 8'h14;
    localparam logic [7:0] OFF_PROTECT = 8'h24;
    localparam logic [7:0] OFF_CALIB   = 8'h3C;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ST_WR_ALLOWED = 2;
    localparam int ST_INIT_READY = 6;
    localparam int ST_INIT_EN    = 7;
    localparam int ST_ALARM      = 8;
    localparam int ST_WAKEUP     = 10;
    localparam int ST_TSTAMP     = 11;
    localparam int ST_TS_OVR     = 12;
    localparam int ST_TAMPER0    = 13;
    localparam int ST_RECAL      = 16;
    localparam int CT_WU_SEL_LSB = 0;
    localparam int CT_WU_EN      = 10;
    localparam int DV_SYNC_LSB   = 0;
    localparam int DV_ASYNC_LSB  = 16;
    localparam int ASYNC_W       = 7;
    localparam int SYNC_W        = 15;
    localparam int RELOAD_W      = 16;
    localparam int CALIB_W       = 16;
    localparam int TAMPER_N      = 3;
    // ----------------------------------------------------------------
    // reset values and keys
    // ----------------------------------------------------------------
    localparam logic [31:0] DIVIDER_RST = 32'h007F00FF;
    localparam logic [31:0] RELOAD_RST  = 32'h0000FFFF;
    // unlock keys: arbitrary values
    localparam logic [15:0] KEY_FIRST   = 16'h00A5;
    localparam logic [15:0] KEY_SECOND  = 16'h005A;
    // ----------------------------------------------------------------
    // timing in source-clock ticks
    // ----------------------------------------------------------------
    localparam int INIT_DELAY_TICKS = 2;
    localparam int WA_DELAY_TICKS   = 2;

    typedef enum logic [1:0] {
        RSP_LOCKED = 2'b00,
        RSP_KEY1   = 2'b01,
        RSP_OPEN   = 2'b10
    } rsp_lock_t;
endpackage

// *** hw/rsp_tick_if.sv ***
`timescale 1ns/10ps
interface rsp_tick_if;
    logic src_tick;
    logic halt;
    logic divided_tick;
    logic second_tick;
    modport src  (input src_tick, input halt, output divided_tick, output second_tick);
    modport sink (input src_tick, input divided_tick, input second_tick);
endinterface

// *** hw/rsp_prescaler.sv ***
`timescale 1ns/10ps
module rsp_prescaler
    import rsp_pkg::*;
#(
    parameter int AW = rsp_pkg::ASYNC_W,
    parameter int SW = rsp_pkg::SYNC_W
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic [AW-1:0] async_divider,
    input  wire logic [SW-1:0] sync_divider,
    rsp_tick_if.src            ti
);
    logic [AW-1:0] a_cnt;
    logic [SW-1:0] s_cnt;
    logic          a_wrap;
    logic          s_wrap;

    assign a_wrap = ti.src_tick && (a_cnt == '0);
    assign s_wrap = a_wrap && (s_cnt == '0);

    // counters reload while halted, so counting restarts from new values
    always_ff @(posedge clk_sys) begin
        if (rst || (ce && ti.halt)) begin
            a_cnt           <= async_divider;
            s_cnt           <= sync_divider;
            ti.divided_tick <= 1'b0;
            ti.second_tick  <= 1'b0;
        end else if (ce) begin
            ti.divided_tick <= a_wrap; // [R13]
            ti.second_tick  <= s_wrap; // [R13]
            if (ti.src_tick) begin
                a_cnt <= a_wrap ? async_divider : a_cnt - 1'b1;
            end
            if (a_wrap) begin
                s_cnt <= s_wrap ? sync_divider : s_cnt - 1'b1;
            end
        end
    end
endmodule

// *** hw/rsp_wakeup.sv ***
`timescale 1ns/10ps
module rsp_wakeup
    import rsp_pkg::*;
#(
    parameter int RW = rsp_pkg::RELOAD_W
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          enable,
    input  wire logic [2:0]    clock_select,
    input  wire logic [RW-1:0] reload,
    rsp_tick_if.sink           ti,
    output logic               expire,
    output logic               write_allowed
);
    logic [3:0]                    pre_cnt;
    logic                          count_tick;
    logic [RW:0]                   reload_full;
    logic [RW:0]                   cnt;
    logic                          running;
    logic [WA_DELAY_TICKS-1:0]     en_pipe;

    // source/16, /8, /4, /2, then second tick
    assign count_tick = clock_select[2] ? ti.second_tick :
                        (ti.src_tick && (pre_cnt | ~(4'hF >> clock_select[1:0])) == 4'hF);
    assign reload_full = clock_select[2] ? {clock_select[1], reload} // [R16]
                                         : {1'b0, reload};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pre_cnt <= 4'h0;
            en_pipe <= '0;
        end else if (ce && ti.src_tick) begin
            pre_cnt <= pre_cnt + 4'h1;
            en_pipe <= {en_pipe[WA_DELAY_TICKS-2:0], enable};
        end
    end

    assign write_allowed = ~en_pipe[WA_DELAY_TICKS-1]; // [R19]

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt     <= '0;
            running <= 1'b0;
            expire  <= 1'b0;
        end else if (ce) begin
            expire <= 1'b0;
            if (!enable) begin
                running <= 1'b0;
            end else if (!running) begin
                cnt     <= reload_full; // [R17]
                running <= 1'b1;
            end else if (count_tick) begin
                if (cnt == '0) begin
                    expire <= 1'b1; // [R15]
                    cnt    <= reload_full;
                end else begin
                    cnt <= cnt - 1'b1;
                end
            end
        end
    end
endmodule

// *** hw/rsp_top.sv ***
`timescale 1ns/10ps
// Behaviour
// [R1] init ready shows initialization state
// [R2] init mode halts counting, restarts fresh
// [R3] alarm match sets flag, zero clears
// [R4] wakeup zero sets flag, zero clears
// [R5] software clears wakeup flag early enough
// [R6] timestamp event sets flag, zero clears
// [R7] timestamp while flagged sets overrun flag
// [R8] software clears overrun after timestamp flag
// [R9] three tamper inputs, three sticky flags
// [R10] calibration write sets pending, locks register
// [R11] divider writable only in init, unlocked
// [R12] software writes divider in two accesses
// [R13] two-stage divider produces second tick
// [R14] reload writable only when allowed, unlocked
// [R15] wakeup flag every reload period
// [R16] top select bit widens counter to 17
// [R17] first wakeup one full period after enable
// [R18] software avoids zero reload at div2
// [R19] write-allowed follows enable by two ticks
// [R20] writing one keeps flag, reserved reads zero
module rsp_top
    import rsp_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic [rsp_pkg::ADDR_W-1:0]    addr,
    input  wire logic [rsp_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [rsp_pkg::DATA_W-1:0]    rdata,
    input  wire logic                          rtc_source_clock,
    input  wire logic                          alarm_match,
    input  wire logic                          timestamp_pin,
    input  wire logic [rsp_pkg::TAMPER_N-1:0]  tamper_pin,
    input  wire logic                          calib_applied,
    output logic                               second_tick,
    output logic                               divided_tick,
    output logic                               calendar_halt,
    output logic      [rsp_pkg::CALIB_W-1:0]   calib_value,
    output logic                               wakeup_expired_flag,
    output logic                               alarm_match_flag
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    rsp_tick_if ti ();

    logic [2:0]                src_sync;
    logic [1:0]                ts_sync;
    logic                      ts_last;
    logic [TAMPER_N-1:0]       tp_sync0;
    logic [TAMPER_N-1:0]       tp_sync1;
    logic [TAMPER_N-1:0]       tp_last;
    logic                      src_tick;
    logic                      ts_event;
    logic [TAMPER_N-1:0]       tp_event;

    rsp_lock_t                 lock_state;
    rsp_lock_t                 next_lock_state;
    logic                      unlocked;

    logic                      init_mode_enable;
    logic                      init_ready_flag;
    logic [1:0]                init_delay;
    logic [2:0]                wakeup_clock_select;
    logic                      wakeup_timer_enable;
    logic [ASYNC_W-1:0]        async_divider;
    logic [SYNC_W-1:0]         sync_divider;
    logic [RELOAD_W-1:0]       wakeup_reload;
    logic [CALIB_W-1:0]        calib_reg;

    logic                      timestamp_flag;
    logic                      timestamp_overrun_flag;
    logic [TAMPER_N-1:0]       tamper_flags;
    logic                      recal_pending_flag;
    logic                      wakeup_write_allowed_flag;
    logic                      wakeup_expire;

    logic                      wr_ctrl;
    logic                      wr_status;
    logic                      wr_divider;
    logic                      wr_reload;
    logic                      wr_protect;
    logic                      wr_calib;
    logic [DATA_W-1:0]         status_word;
    logic [DATA_W-1:0]         ctrl_word;
    logic [DATA_W-1:0]         divider_word;
    logic [DATA_W-1:0]         next_rdata;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        sel = (a == off);
    endfunction

    // hardware set wins over a software zero; a one leaves the flag
    function automatic logic rcw0(input logic flag, input logic set,
                                  input logic clr_wr, input logic bitval);
        rcw0 = set || (flag && !(clr_wr && !bitval));
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            src_sync <= 3'h0;
            ts_sync  <= 2'h0;
            ts_last  <= 1'b0;
            tp_sync0 <= '0;
            tp_sync1 <= '0;
            tp_last  <= '0;
        end else if (ce) begin
            src_sync <= {src_sync[1:0], rtc_source_clock};
            ts_sync  <= {ts_sync[0], timestamp_pin};
            ts_last  <= ts_sync[1];
            tp_sync0 <= tamper_pin;
            tp_sync1 <= tp_sync0;
            tp_last  <= tp_sync1;
        end
    end

    assign src_tick = ce && src_sync[1] && !src_sync[2];
    assign ts_event = ce && ts_sync[1] && !ts_last;
    assign tp_event = {TAMPER_N{ce}} & tp_sync1 & ~tp_last;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign wr_ctrl    = wr && ce && sel(addr, OFF_CTRL) && unlocked;
    assign wr_status  = wr && ce && sel(addr, OFF_STATUS);
    assign wr_divider = wr && ce && sel(addr, OFF_DIVIDER)
                        && init_ready_flag && unlocked; // [R11]
    assign wr_reload  = wr && ce && sel(addr, OFF_RELOAD)
                        && wakeup_write_allowed_flag && unlocked; // [R14]
    assign wr_protect = wr && ce && sel(addr, OFF_PROTECT);
    assign wr_calib   = wr && ce && sel(addr, OFF_CALIB)
                        && unlocked && !recal_pending_flag; // [R10]

    // ----------------------------------------------------------------
    // write protection
    // ----------------------------------------------------------------
    assign unlocked = (lock_state == RSP_OPEN);

    always_comb begin
        next_lock_state = lock_state;
        if (wr_protect) begin
            unique case (lock_state)
                RSP_LOCKED: begin
                    next_lock_state = (wdata[15:0] == KEY_FIRST) ? RSP_KEY1 : RSP_LOCKED;
                end
                RSP_KEY1: begin
                    next_lock_state = (wdata[15:0] == KEY_SECOND) ? RSP_OPEN : RSP_LOCKED;
                end
                RSP_OPEN: begin
                    next_lock_state = RSP_LOCKED;
                end
                default: begin
                    next_lock_state = RSP_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_state <= RSP_LOCKED;
        end else if (ce) begin
            lock_state <= next_lock_state;
        end
    end

    // ----------------------------------------------------------------
    // control and configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wakeup_clock_select <= 3'h0;
            wakeup_timer_enable <= 1'b0;
        end else if (wr_ctrl) begin
            wakeup_clock_select <= wdata[CT_WU_SEL_LSB +: 3];
            wakeup_timer_enable <= wdata[CT_WU_EN];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            async_divider <= DIVIDER_RST[DV_ASYNC_LSB +: ASYNC_W];
            sync_divider  <= DIVIDER_RST[DV_SYNC_LSB +: SYNC_W];
        end else if (wr_divider) begin
            async_divider <= wdata[DV_ASYNC_LSB +: ASYNC_W];
            sync_divider  <= wdata[DV_SYNC_LSB +: SYNC_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wakeup_reload <= RELOAD_RST[RELOAD_W-1:0];
        end else if (wr_reload) begin
            wakeup_reload <= wdata[RELOAD_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            calib_reg <= '0;
        end else if (wr_calib) begin
            calib_reg <= wdata[CALIB_W-1:0];
        end
    end

    assign calib_value = calib_reg;

    // ----------------------------------------------------------------
    // initialization mode
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            init_mode_enable <= 1'b0;
        end else if (wr_status && unlocked) begin
            init_mode_enable <= wdata[ST_INIT_EN]; // [R2]
        end
    end

    // ready only after the enable has settled in the source domain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            init_delay      <= 2'h0;
            init_ready_flag <= 1'b0;
        end else if (ce) begin
            if (!init_mode_enable) begin
                init_delay      <= 2'h0;
                init_ready_flag <= 1'b0; // [R1]
            end else if (src_tick && !init_ready_flag) begin
                init_delay      <= init_delay + 2'h1;
                init_ready_flag <= (init_delay == 2'(INIT_DELAY_TICKS - 1)); // [R1]
            end
        end
    end

    // ----------------------------------------------------------------
    // prescaler and wakeup timer
    // ----------------------------------------------------------------
    assign ti.src_tick    = src_tick;
    assign ti.halt        = init_mode_enable; // [R2]
    assign second_tick    = ti.second_tick;
    assign divided_tick   = ti.divided_tick;
    assign calendar_halt  = init_mode_enable; // [R2]

    rsp_prescaler #(
        .AW (ASYNC_W),
        .SW (SYNC_W)
    ) u_prescaler (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .ce            (ce),
        .async_divider (async_divider),
        .sync_divider  (sync_divider),
        .ti            (ti.src)
    );

    rsp_wakeup #(
        .RW (RELOAD_W)
    ) u_wakeup (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .ce            (ce),
        .enable        (wakeup_timer_enable),
        .clock_select  (wakeup_clock_select),
        .reload        (wakeup_reload),
        .ti            (ti.sink),
        .expire        (wakeup_expire),
        .write_allowed (wakeup_write_allowed_flag)
    );

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alarm_match_flag       <= 1'b0;
            wakeup_expired_flag    <= 1'b0;
            timestamp_flag         <= 1'b0;
            timestamp_overrun_flag <= 1'b0;
        end else if (ce) begin
            alarm_match_flag       <= rcw0(alarm_match_flag, alarm_match,
                                           wr_status, wdata[ST_ALARM]); // [R3] [R20]
            wakeup_expired_flag    <= rcw0(wakeup_expired_flag, wakeup_expire,
                                           wr_status, wdata[ST_WAKEUP]); // [R4]
            timestamp_flag         <= rcw0(timestamp_flag, ts_event,
                                           wr_status, wdata[ST_TSTAMP]); // [R6]
            timestamp_overrun_flag <= rcw0(timestamp_overrun_flag,
                                           ts_event && timestamp_flag,
                                           wr_status, wdata[ST_TS_OVR]); // [R7]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < TAMPER_N; gi++) begin : g_tamper
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    tamper_flags[gi] <= 1'b0;
                end else if (ce) begin
                    tamper_flags[gi] <= rcw0(tamper_flags[gi], tp_event[gi],
                                             wr_status, wdata[ST_TAMPER0 + gi]); // [R9]
                end
            end
        end
    endgenerate

    // pending until the consumer reports the new setting in use
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            recal_pending_flag <= 1'b0;
        end else if (ce) begin
            if (wr_calib) begin
                recal_pending_flag <= 1'b1; // [R10]
            end else if (calib_applied) begin
                recal_pending_flag <= 1'b0; // [R10]
            end
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    always_comb begin
        status_word                          = '0; // [R20]
        status_word[ST_WR_ALLOWED]           = wakeup_write_allowed_flag;
        status_word[ST_INIT_READY]           = init_ready_flag;
        status_word[ST_INIT_EN]              = init_mode_enable;
        status_word[ST_ALARM]                = alarm_match_flag;
        status_word[ST_WAKEUP]               = wakeup_expired_flag;
        status_word[ST_TSTAMP]               = timestamp_flag;
        status_word[ST_TS_OVR]               = timestamp_overrun_flag;
        status_word[ST_TAMPER0 +: TAMPER_N]  = tamper_flags;
        status_word[ST_RECAL]                = recal_pending_flag;
    end

    always_comb begin
        ctrl_word                            = '0;
        ctrl_word[CT_WU_SEL_LSB +: 3]        = wakeup_clock_select;
        ctrl_word[CT_WU_EN]                  = wakeup_timer_enable;
    end

    always_comb begin
        divider_word                         = '0;
        divider_word[DV_ASYNC_LSB +: ASYNC_W] = async_divider;
        divider_word[DV_SYNC_LSB +: SYNC_W]   = sync_divider;
    end

    assign next_rdata = sel(addr, OFF_CTRL)    ? ctrl_word :
                        sel(addr, OFF_STATUS)  ? status_word :
                        sel(addr, OFF_DIVIDER) ? divider_word :
                        sel(addr, OFF_RELOAD)  ? {{(DATA_W-RELOAD_W){1'b0}}, wakeup_reload} :
                        sel(addr, OFF_CALIB)   ? {{(DATA_W-CALIB_W){1'b0}}, calib_reg} :
                        '0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= rd ? next_rdata : '0;
        end
    end
endmodule

// *** tb/rsp_top_properties.sv ***
`timescale 1ns/10ps
module rsp_top_checker
    import rsp_pkg::*;
(
    input wire logic                       clk_sys,
    input wire logic                       rst,
    input wire logic [rsp_pkg::ADDR_W-1:0] addr,
    input wire logic [rsp_pkg::DATA_W-1:0] wdata,
    input wire logic                       wr,
    input wire logic                       rd,
    input wire logic [rsp_pkg::DATA_W-1:0] rdata,
    input wire logic                       alarm_match,
    input wire logic                       alarm_match_flag,
    input wire logic                       wakeup_expired_flag,
    input wire logic                       calendar_halt,
    input wire logic                       divided_tick
);
    // ------------------------------------------------------------
    // status flags, read-back, halt and divided tick
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire st_wr = wr && addr == OFF_STATUS;
    sequence s_stat_rd;
        rd && addr == OFF_STATUS;
    endsequence
    sequence s_alarm_clr;
        st_wr && !wdata[ST_ALARM] && !alarm_match;
    endsequence
    alarm_set_a: assert property (alarm_match |=> alarm_match_flag)
        else $error("alarm flag not set");
    alarm_clear_a: assert property (s_alarm_clr |=> !alarm_match_flag)
        else $error("alarm flag not cleared");
    alarm_keep_a: assert property (
        alarm_match_flag && !(st_wr && !wdata[ST_ALARM]) |=> alarm_match_flag)
        else $error("alarm flag lost");
    wake_keep_a: assert property (
        wakeup_expired_flag && !(st_wr && !wdata[ST_WAKEUP]) |=> wakeup_expired_flag)
        else $error("wakeup flag lost");
    status_read_a: assert property (s_stat_rd |=> rdata[31:17] == '0 && !rdata[9]
        && rdata[ST_ALARM] == $past(alarm_match_flag)
        && rdata[ST_WAKEUP] == $past(wakeup_expired_flag))
        else $error("status read wrong");
    halt_read_a: assert property (s_stat_rd |=> rdata[ST_INIT_EN] == $past(calendar_halt))
        else $error("init enable read wrong");
    halt_cause_a: assert property ($changed(calendar_halt) |-> $past(st_wr))
        else $error("halt changed without write");
    tick_pulse_a: assert property (divided_tick |=> !divided_tick)
        else $error("divided tick too long");
endmodule
bind rsp_top rsp_top_checker u_chk (.*);

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
    import rsp_pkg::*;
    logic                clk_sys, rst, ce, wr, rd, rtc_source_clock, alarm_match, calib_applied;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata, rdata;
    logic [3:0]          pins;
    logic                second_tick, divided_tick, calendar_halt;
    logic                wakeup_expired_flag, alarm_match_flag;
    logic [CALIB_W-1:0]  calib_value;
    wire                 timestamp_pin = pins[3];
    wire [TAMPER_N-1:0]  tamper_pin = pins[2:0];
    int                  n_mismatch, checks, cyc, nd, ns, t0, t1;
    logic [7:0]          ra [5] = '{OFF_DIVIDER, OFF_RELOAD, OFF_STATUS, OFF_PROTECT, 8'h40};
    logic [31:0]         re [5] = '{DIVIDER_RST, RELOAD_RST, 32'h4, 32'h0, 32'h0};
    rsp_top u_dut (.*);
    // ------------------------------------------------------------
    // clocks, bus tasks, verdict
    // ------------------------------------------------------------
    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        rtc_source_clock = 0;
        forever #200 rtc_source_clock = ~rtc_source_clock;
    end
    always @(posedge clk_sys) begin
        cyc++;
        nd += divided_tick;
        ns += second_tick;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask
    task automatic pulse(input int b);
        @(posedge clk_sys);
        pins[b] <= 1'b1;
        repeat (6) @(posedge clk_sys);
        pins[b] <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic wait_wk;
        for (int i = 0; i < 300 && wakeup_expired_flag !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        {rst, ce, wr, rd, addr, wdata, pins, alarm_match, calib_applied} = '0;
        rst = 1;
        ce = 1;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rreg(ra[i], '1, re[i]);
        wreg(OFF_DIVIDER, 32'h00010001);
        rreg(OFF_DIVIDER, '1, DIVIDER_RST);
        $display("done reset and lock");
        wreg(OFF_PROTECT, {16'h0000, KEY_FIRST});
        wreg(OFF_PROTECT, {16'h0000, KEY_SECOND});
        wreg(OFF_STATUS, 32'h80);
        repeat (40) @(posedge clk_sys);
        rreg(OFF_STATUS, 32'hC0, 32'hC0);
        chk(calendar_halt, 1);
        wreg(OFF_DIVIDER, 32'h000100FF);
        wreg(OFF_DIVIDER, 32'h00010001);
        rreg(OFF_DIVIDER, '1, 32'h00010001);
        wreg(OFF_STATUS, 32'h0);
        rreg(OFF_STATUS, 32'hC0, 32'h0);
        repeat (20) @(posedge clk_sys);
        #1 {t0, t1} = {nd, ns};
        repeat (128) @(posedge clk_sys);
        #1 chk(nd - t0, 8);
        chk(ns - t1, 4);
        $display("done divider");
        @(posedge clk_sys);
        alarm_match <= 1'b1;
        @(posedge clk_sys);
        alarm_match <= 1'b0;
        wreg(OFF_STATUS, 32'h0000FD00);
        rreg(OFF_STATUS, 32'h100, 32'h100);
        wreg(OFF_STATUS, 32'h0000FC00);
        rreg(OFF_STATUS, 32'h100, 32'h0);
        pulse(3);
        rreg(OFF_STATUS, 32'h1800, 32'h0800);
        pulse(3);
        rreg(OFF_STATUS, 32'h1800, 32'h1800);
        wreg(OFF_STATUS, 32'h0000F500);
        wreg(OFF_STATUS, 32'h0000E500);
        rreg(OFF_STATUS, 32'h1800, 32'h0);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            rreg(OFF_STATUS, 32'hE000, 32'h2000 << i);
            wreg(OFF_STATUS, 32'h0);
        end
        $display("done event flags");
        wreg(OFF_CALIB, 32'h1234);
        wreg(OFF_CALIB, 32'h5678);
        rreg(OFF_STATUS, 32'h10000, 32'h10000);
        chk(calib_value, 32'h1234);
        @(posedge clk_sys);
        calib_applied <= 1'b1;
        @(posedge clk_sys);
        calib_applied <= 1'b0;
        rreg(OFF_STATUS, 32'h10000, 32'h0);
        $display("done calibration");
        wreg(OFF_RELOAD, 32'h3);
        wreg(OFF_CTRL, 32'h403);
        #1 t0 = cyc;
        wait_wk;
        t1 = cyc;
        chk((t1 - t0) inside {[48:84]}, 1);
        wreg(OFF_STATUS, 32'h0);
        rreg(OFF_STATUS, 32'h404, 32'h0);
        wait_wk;
        chk(cyc - t1, 64);
        wreg(OFF_RELOAD, 32'h7);
        rreg(OFF_RELOAD, '1, 32'h3);
        wreg(OFF_CTRL, 32'h3);
        repeat (40) @(posedge clk_sys);
        rreg(OFF_STATUS, 32'h4, 32'h4);
        $display("done wakeup");
        report_and_stop;
    end
endmodule
